// ### hdl/lacx_pkg.sv
// Package with constants and carrier types for the level-advance, branch and command execution block.
package lacx_pkg;

   localparam logic [7:0] OP_LEVEL_ADVANCE = 8'hF1;
   localparam logic [7:0] OP_CPU_COMMAND   = 8'hF4;
   localparam logic [7:0] OP_BRANCH_DIRECT = 8'hC0;
   localparam logic [7:0] OP_BRANCH_IDX1   = 8'hD0;
   localparam logic [7:0] OP_BRANCH_IDX2   = 8'hE0;

   // Flag positions in the flag byte: index 7-n holds condition bit n.
   localparam int FLAG_EQUAL    = 7;
   localparam int FLAG_LOW      = 6;
   localparam int FLAG_HIGH     = 5;
   localparam int FLAG_DEC_OVF  = 4;
   localparam int FLAG_TEST_F   = 3;
   localparam int FLAG_BIN_OVF  = 2;

   localparam logic [7:0] FN_SUPERVISOR_REQUEST = 8'h10;
   localparam logic [7:0] FN_LEVEL7_CONTROL     = 8'h20;
   localparam logic [7:0] FN_LOAD_MODE          = 8'h30;
   localparam logic [7:0] FN_DIAG_MODE          = 8'h40;

   localparam logic [7:0] ACT_00 = 8'h00;
   localparam logic [7:0] ACT_01 = 8'h01;
   localparam logic [7:0] ACT_02 = 8'h02;
   localparam logic [7:0] ACT_03 = 8'h03;

   localparam logic [7:0] Q_BRANCH_NOP    = 8'h80;
   localparam logic [7:0] Q_BRANCH_ALWAYS = 8'h00;

   localparam logic [7:0]  RST_FLAGS      = 8'h00;
   localparam logic [7:0]  RST_MODE       = 8'h00;
   localparam logic [15:0] RST_ADDR       = 16'h0000;
   localparam int          MODE_IO256_BIT = 0;

   localparam logic [15:0] LEN_LEVEL_ADVANCE = 16'h0003;
   localparam logic [15:0] LEN_CPU_COMMAND   = 16'h0003;
   localparam logic [15:0] LEN_BRANCH        = 16'h0004;
   localparam logic [15:0] LEN_BRANCH_INDEX  = 16'h0003;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  qual;
      logic [7:0]  rbyte;
      logic [15:0] operand;
      logic [15:0] addr;
   } lacx_instr_t;

   typedef struct packed {
      logic zero;
      logic negative;
      logic carry_out;
   } lacx_zadd_t;

   typedef enum logic [1:0] {
      LACX_IDLE  = 2'b00,
      LACX_EXEC  = 2'b01,
      LACX_DONE  = 2'b10
   } lacx_state_t;

endpackage : lacx_pkg

// ### hdl/lacx_qual_decode.sv
// Branch qualifier decoder that forms the take decision and flag clear mask.
module lacx_qual_decode
(
   input  wire logic [7:0] qual_i,
   input  wire logic [7:0] flags_i,
   output logic            take_o,
   output logic            nop_o,
   output logic [7:0]      clear_mask_o
);

   logic [7:0] sel;
   logic       any_set;

   always_comb
   begin
      // Qualifier bits 0 to 5 name flags 7 down to 2, so the field is turned end for end.
      sel     = {qual_i[0], qual_i[1], qual_i[2], qual_i[3], qual_i[4], qual_i[5], 2'b00};
      any_set = |(sel & flags_i);
      nop_o   = 1'b0;
      take_o  = 1'b0;
      if ((qual_i == lacx_pkg::Q_BRANCH_NOP) ||
          (!qual_i[7] && (qual_i[2:0] == 3'h7)))
      begin
         nop_o = 1'b1;
      end
      else if ((qual_i == lacx_pkg::Q_BRANCH_ALWAYS) ||
               (qual_i[7] && (qual_i[2:0] == 3'h7)))
      begin
         take_o = 1'b1;
      end
      else if (qual_i[7])
      begin
         take_o = any_set;
      end
      else
      begin
         take_o = !any_set;
      end
      // Only decimal overflow and test false are cleared when selected.
      clear_mask_o = nop_o ? 8'h00 : (sel & 8'h18);
   end

endmodule : lacx_qual_decode

// ### hdl/lacx_exec.sv
// Execution unit for level advance, flag branch, cpu command and zoned add flag results.
// Operation
// - Zoned add sets equal, low or high flag for zero, negative, positive.
// - Zoned add sets decimal overflow on carry out of leftmost digit.
// - Zoned add leaves test false and binary overflow unchanged.
// - Level advance qualifier: device select 0-3, modifier bit 4, test code 5-7.
// - Nonzero device select with feature and condition: switch level, re-enter here.
// - Conditional with feature and condition absent: continue to following instruction.
// - Without feature, conditional form loops until condition clears, then continues.
// - Zero select, zero modifier, code 000 is the nonlooping unconditional form.
// - Nonlooping form with feature: switch level, re-enter at following instruction.
// - Nonlooping form without feature: go straight to following instruction.
// - Looping form with feature: switch level, re-enter at own address.
// - Looping form without feature re-executes forever; interrupts still serviced.
// - Level advance and cpu command leave all flags unchanged.
// - Branch qualifier bit 0 picks all-zero or any-one test over bits 2-7.
// - Qualifier 80, x7 or xF with x 0-7 makes branch a no-operation.
// - Qualifier 00, x7 or xF with x 8-F branches unconditionally.
// - Branch clears decimal overflow and test false when tested only.
// - Cpu command applies third byte action to qualifier selected function.
// - Diagnostic speed change takes effect from the following instruction.
// - Reset and initial program load return to normal speed mode.
// - Cpu command never alters the I/O above 256K mode bit.
// - Function 10: action 00 requests level 0, action 02 resets it.
// - Function 20: actions 00-03 disable, enable, reset-disable, reset-enable level 7.
// - Function 30 loads action byte into current program mode register.
// - Function 40: action 00 slow diagnostic mode, action 02 fast mode.
module lacx_exec
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 clk_en_i,
   input  wire logic                 initial_program_load_i,
   input  wire logic                 start_i,
   input  wire lacx_pkg::lacx_instr_t instr_i,
   input  wire logic                 zadd_valid_i,
   input  wire lacx_pkg::lacx_zadd_t zadd_i,
   input  wire logic                 dual_level_feature_i,
   input  wire logic [15:0]          index_reg_one_i,
   input  wire logic [15:0]          index_reg_two_i,
   input  wire logic [7:0]           dev_status_i,
   input  wire logic                 interrupt_pending_i,
   input  wire logic                 int_level7_reset_done_i,
   output logic                      done_o,
   output logic [15:0]               instruction_pointer_o,
   output logic                      level_switch_o,
   output logic [15:0]               reentry_addr_o,
   output logic [15:0]               addr_recall_o,
   output logic [7:0]                flags_o,
   output logic [7:0]                program_mode_reg_o,
   output logic                      diag_slow_o,
   output logic                      supervisor_request_o,
   output logic                      level0_reset_o,
   output logic                      level7_enable_o,
   output logic                      level7_reset_o,
   output logic                      loop_wait_o
);

   lacx_pkg::lacx_state_t state_r;
   lacx_pkg::lacx_instr_t instr_r;
   logic [7:0]            dev_sync1_r;
   logic [7:0]            dev_sync2_r;
   logic [7:0]            dev_sync3_r;
   logic [7:0]            dev_stable_r;
   logic                  diag_pending_r;
   logic                  diag_pending_val_r;
   logic [7:0]            mode_pending_r;
   logic                  mode_pending_val_r;
   logic                  take;
   logic                  nop;
   logic [7:0]            clear_mask;
   logic [3:0]            dev_sel;
   logic                  modifier;
   logic [2:0]            test_code;
   logic                  cond_present;
   logic [15:0]           next_addr;
   logic [15:0]           target;

   function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
      add16 = a + b;
   endfunction : add16

   lacx_qual_decode u_qual
   (
      .qual_i       (instr_r.qual),
      .flags_i      (flags_o),
      .take_o       (take),
      .nop_o        (nop),
      .clear_mask_o (clear_mask)
   );

   always_comb
   begin
      dev_sel   = instr_r.qual[7:4];
      modifier  = instr_r.qual[3];
      test_code = instr_r.qual[2:0];
      // Condition code selects one status line of the addressed device.
      cond_present = dev_stable_r[test_code];
      unique case (instr_r.opcode)
         lacx_pkg::OP_BRANCH_DIRECT:
         begin
            next_addr = add16(instr_r.addr, lacx_pkg::LEN_BRANCH);
            target    = instr_r.operand;
         end
         lacx_pkg::OP_BRANCH_IDX1:
         begin
            next_addr = add16(instr_r.addr, lacx_pkg::LEN_BRANCH_INDEX);
            target    = add16(index_reg_one_i, {8'h00, instr_r.operand[7:0]});
         end
         lacx_pkg::OP_BRANCH_IDX2:
         begin
            next_addr = add16(instr_r.addr, lacx_pkg::LEN_BRANCH_INDEX);
            target    = add16(index_reg_two_i, {8'h00, instr_r.operand[7:0]});
         end
         default:
         begin
            next_addr = add16(instr_r.addr, lacx_pkg::LEN_LEVEL_ADVANCE);
            target    = lacx_pkg::RST_ADDR;
         end
      endcase
   end

   // Device status passes three flops; a change is accepted once stages two and three agree.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         dev_sync1_r  <= 8'h00;
         dev_sync2_r  <= 8'h00;
         dev_sync3_r  <= 8'h00;
         dev_stable_r <= 8'h00;
      end
      else if (clk_en_i)
      begin
         dev_sync1_r <= dev_status_i;
         dev_sync2_r <= dev_sync1_r;
         dev_sync3_r <= dev_sync2_r;
         dev_stable_r <= (dev_sync2_r & dev_sync3_r) | (dev_stable_r & (dev_sync2_r | dev_sync3_r));
      end
   end

   // Sequencer.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         state_r <= lacx_pkg::LACX_IDLE;
         instr_r <= '0;
      end
      else if (clk_en_i)
      begin
         unique case (state_r)
            lacx_pkg::LACX_IDLE:
            begin
               if (start_i)
               begin
                  instr_r <= instr_i;
                  state_r <= lacx_pkg::LACX_EXEC;
               end
            end
            lacx_pkg::LACX_EXEC:
            begin
               state_r <= lacx_pkg::LACX_DONE;
            end
            lacx_pkg::LACX_DONE:
            begin
               state_r <= lacx_pkg::LACX_IDLE;
            end
            default:
            begin
               state_r <= lacx_pkg::LACX_IDLE;
            end
         endcase
      end
   end

   // Flow control and level switch outcome.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         done_o                <= 1'b0;
         instruction_pointer_o <= lacx_pkg::RST_ADDR;
         level_switch_o        <= 1'b0;
         reentry_addr_o        <= lacx_pkg::RST_ADDR;
         addr_recall_o         <= lacx_pkg::RST_ADDR;
         loop_wait_o           <= 1'b0;
      end
      else if (clk_en_i)
      begin
         done_o         <= 1'b0;
         level_switch_o <= 1'b0;
         if (state_r == lacx_pkg::LACX_EXEC)
         begin
            done_o                <= 1'b1;
            instruction_pointer_o <= next_addr;
            loop_wait_o           <= 1'b0;
            if (instr_r.opcode == lacx_pkg::OP_LEVEL_ADVANCE)
            begin
               if (dev_sel != 4'h0)
               begin
                  if (dual_level_feature_i && cond_present)
                  begin
                     level_switch_o <= 1'b1;
                     reentry_addr_o <= instr_r.addr;
                  end
                  else if (!dual_level_feature_i && cond_present)
                  begin
                     instruction_pointer_o <= instr_r.addr;
                     loop_wait_o           <= 1'b1;
                  end
                  // Otherwise the following instruction runs.
               end
               else if (!modifier && (test_code == 3'b000))
               begin
                  if (dual_level_feature_i)
                  begin
                     level_switch_o <= 1'b1;
                     reentry_addr_o <= next_addr;
                  end
                  // Without the feature the following instruction runs.
               end
               else if (dual_level_feature_i)
               begin
                  level_switch_o <= 1'b1;
                  reentry_addr_o <= instr_r.addr;
               end
               else
               begin
                  // Interrupts are taken outside; this level simply re-executes.
                  instruction_pointer_o <= instr_r.addr;
                  loop_wait_o           <= !interrupt_pending_i;
               end
            end
            else if ((instr_r.opcode == lacx_pkg::OP_BRANCH_DIRECT) ||
                     (instr_r.opcode == lacx_pkg::OP_BRANCH_IDX1) ||
                     (instr_r.opcode == lacx_pkg::OP_BRANCH_IDX2))
            begin
               if (take && !nop)
               begin
                  instruction_pointer_o <= target;
                  addr_recall_o         <= next_addr;
               end
            end
         end
      end
   end

   // Condition flags.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         flags_o <= lacx_pkg::RST_FLAGS;
      end
      else if (clk_en_i)
      begin
         if (zadd_valid_i)
         begin
            flags_o[lacx_pkg::FLAG_EQUAL] <= zadd_i.zero;
            flags_o[lacx_pkg::FLAG_LOW]   <= !zadd_i.zero && zadd_i.negative;
            flags_o[lacx_pkg::FLAG_HIGH]  <= !zadd_i.zero && !zadd_i.negative;
            if (zadd_i.carry_out)
            begin
               flags_o[lacx_pkg::FLAG_DEC_OVF] <= 1'b1;
            end
            // Test false and binary overflow bits are not written.
         end
         else if ((state_r == lacx_pkg::LACX_EXEC) &&
                  ((instr_r.opcode == lacx_pkg::OP_BRANCH_DIRECT) ||
                   (instr_r.opcode == lacx_pkg::OP_BRANCH_IDX1) ||
                   (instr_r.opcode == lacx_pkg::OP_BRANCH_IDX2)))
         begin
            flags_o <= flags_o & ~clear_mask;
         end
         // Level advance and cpu command match neither arm here, so the flags keep their value.
      end
   end

   // Cpu command actions; mode and speed changes are staged until the next instruction starts.
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         program_mode_reg_o   <= lacx_pkg::RST_MODE;
         diag_slow_o          <= 1'b0;
         diag_pending_r       <= 1'b0;
         diag_pending_val_r   <= 1'b0;
         mode_pending_r       <= lacx_pkg::RST_MODE;
         mode_pending_val_r   <= 1'b0;
         supervisor_request_o <= 1'b0;
         level0_reset_o       <= 1'b0;
         level7_enable_o      <= 1'b0;
         level7_reset_o       <= 1'b0;
      end
      else if (clk_en_i)
      begin
         level0_reset_o <= 1'b0;
         level7_reset_o <= 1'b0;
         if (initial_program_load_i)
         begin
            diag_slow_o    <= 1'b0;
            diag_pending_r <= 1'b0;
         end
         else if (start_i && (state_r == lacx_pkg::LACX_IDLE))
         begin
            if (diag_pending_r)
            begin
               diag_slow_o    <= diag_pending_val_r;
               diag_pending_r <= 1'b0;
            end
            if (mode_pending_val_r)
            begin
               program_mode_reg_o <= mode_pending_r;
               mode_pending_val_r <= 1'b0;
            end
         end
         if (int_level7_reset_done_i)
         begin
            supervisor_request_o <= supervisor_request_o;
         end
         if ((state_r == lacx_pkg::LACX_EXEC) && (instr_r.opcode == lacx_pkg::OP_CPU_COMMAND))
         begin
            unique case (instr_r.qual)
               lacx_pkg::FN_SUPERVISOR_REQUEST:
               begin
                  if (instr_r.rbyte == lacx_pkg::ACT_00)
                  begin
                     supervisor_request_o <= 1'b1;
                  end
                  else if (instr_r.rbyte == lacx_pkg::ACT_02)
                  begin
                     supervisor_request_o <= 1'b0;
                     level0_reset_o       <= 1'b1;
                  end
               end
               lacx_pkg::FN_LEVEL7_CONTROL:
               begin
                  if (instr_r.rbyte[7:2] == 6'h00)
                  begin
                     level7_enable_o <= instr_r.rbyte[0];
                     level7_reset_o  <= instr_r.rbyte[1];
                  end
               end
               lacx_pkg::FN_LOAD_MODE:
               begin
                  mode_pending_r     <= instr_r.rbyte;
                  mode_pending_r[7 - lacx_pkg::MODE_IO256_BIT] <=
                     program_mode_reg_o[7 - lacx_pkg::MODE_IO256_BIT];
                  mode_pending_val_r <= 1'b1;
               end
               lacx_pkg::FN_DIAG_MODE:
               begin
                  if (instr_r.rbyte == lacx_pkg::ACT_00)
                  begin
                     diag_pending_r     <= 1'b1;
                     diag_pending_val_r <= 1'b1;
                  end
                  else if (instr_r.rbyte == lacx_pkg::ACT_02)
                  begin
                     diag_pending_r     <= 1'b1;
                     diag_pending_val_r <= 1'b0;
                  end
               end
               default:
               begin
                  level7_reset_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : lacx_exec

// ### tb/lacx_exec_props.sv
// Checker of port relations of the execution unit, bound to its top module.
module lacx_exec_props
(
   input wire logic                  ref_clk_i,
   input wire logic                  rst_n_i,
   input wire logic                  clk_en_i,
   input wire logic                  initial_program_load_i,
   input wire logic                  start_i,
   input wire lacx_pkg::lacx_instr_t instr_i,
   input wire logic                  zadd_valid_i,
   input wire lacx_pkg::lacx_zadd_t  zadd_i,
   input wire logic                  dual_level_feature_i,
   input wire logic                  done_o,
   input wire logic [15:0]           instruction_pointer_o,
   input wire logic                  level_switch_o,
   input wire logic [15:0]           reentry_addr_o,
   input wire logic [7:0]            flags_o,
   input wire logic [7:0]            program_mode_reg_o,
   input wire logic                  diag_slow_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic                  busy_r;
   logic                  dirty_r;
   logic                  acc;
   logic [7:0]            flg_r;
   lacx_pkg::lacx_instr_t ins_r;
   lacx_pkg::lacx_zadd_t  zq_r;
   assign acc = start_i && clk_en_i && (!busy_r || done_o);
   // Tracks the instruction in flight and whether a zoned add disturbed its flags.
   always_ff @(posedge ref_clk_i)
   begin
      busy_r <= rst_n_i && (acc || (busy_r && !done_o));
      dirty_r <= zadd_valid_i || (dirty_r && !acc);
      zq_r <= zadd_i;
      if (acc)
      begin
         ins_r <= instr_i;
         flg_r <= flags_o;
      end
   end
   default clocking dc @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);
   zadd_flags_a:
      assert property (zadd_valid_i && clk_en_i |=> flags_o[7:5] == {zq_r.zero,
         zq_r.negative && !zq_r.zero, !zq_r.zero && !zq_r.negative})
      else $error("zoned add result flags wrong");
   dec_ovf_a:
      assert property (zadd_valid_i && clk_en_i && zadd_i.carry_out |=> flags_o[4])
      else $error("decimal overflow not set");
   zadd_keep_a:
      assert property (zadd_valid_i && clk_en_i |=> $stable(flags_o[3:2]))
      else $error("zoned add changed untouched flags");
   cmd_flags_a:
      assert property (done_o && !dirty_r && (ins_r.opcode == 8'hF1 || ins_r.opcode == 8'hF4)
         |-> flags_o == flg_r)
      else $error("flags changed by advance or command");
   switch_reent_a:
      assert property (level_switch_o |-> done_o && reentry_addr_o ==
         (ins_r.qual == 8'h00 ? ins_r.addr + 16'h0003 : ins_r.addr))
      else $error("level switch reentry wrong");
   no_feat_a:
      assert property (done_o && !dual_level_feature_i |-> !level_switch_o)
      else $error("level switch without feature");
   nop_br_a:
      assert property (done_o && ins_r.opcode == 8'hC0 && ins_r.qual == 8'h80
         |-> instruction_pointer_o == ins_r.addr + 16'h0004)
      else $error("no-op branch moved wrongly");
   always_br_a:
      assert property (done_o && ins_r.opcode == 8'hC0 && ins_r.qual == 8'h00
         |-> instruction_pointer_o == ins_r.operand)
      else $error("unconditional branch missed");
   pmr_io_a:
      assert property ($stable(program_mode_reg_o[7]))
      else $error("high address mode bit changed");
   diag_ipl_a:
      assert property (initial_program_load_i && clk_en_i |=> !diag_slow_o)
      else $error("slow mode survived load");
endmodule : lacx_exec_props

bind lacx_exec lacx_exec_props u_props
(
   .ref_clk_i, .rst_n_i, .clk_en_i, .initial_program_load_i, .start_i, .instr_i,
   .zadd_valid_i, .zadd_i, .dual_level_feature_i, .done_o, .instruction_pointer_o,
   .level_switch_o, .reentry_addr_o, .flags_o, .program_mode_reg_o, .diag_slow_o
);

// ### tb/lacx_dev_model.sv
// Attached device model that presents status conditions as steady levels.
module lacx_dev_model
(
   input  wire logic       ref_clk_i,
   input  wire logic       set_i,
   input  wire logic [7:0] cond_i,
   output logic [7:0]      dev_status_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial dev_status_o = 8'h00;
   // Status only moves when told, so it stays put through every evaluation.
   always @(posedge ref_clk_i)
   begin
      if (set_i)
      begin
         dev_status_o <= cond_i;
      end
   end
endmodule : lacx_dev_model

// ### tb/lacx_exec_tb_top.sv
// Self-checking testbench for the level advance, branch and command execution unit.
module lacx_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk_i, rst_n_i, clk_en_i, initial_program_load_i, start_i, zadd_valid_i;
   logic dual_level_feature_i, interrupt_pending_i, int_level7_reset_done_i, done_o;
   logic level_switch_o, diag_slow_o, supervisor_request_o, level0_reset_o;
   logic level7_enable_o, level7_reset_o, loop_wait_o, st_set;
   logic [15:0] index_reg_one_i, index_reg_two_i, instruction_pointer_o, reentry_addr_o;
   logic [15:0] addr_recall_o;
   logic [7:0] dev_status_i, flags_o, program_mode_reg_o, st_val;
   lacx_pkg::lacx_instr_t instr_i;
   lacx_pkg::lacx_zadd_t zadd_i;
   int fail_count, num_checks, cycles;
   lacx_exec u_dut
   (
      .ref_clk_i, .rst_n_i, .clk_en_i, .initial_program_load_i, .start_i, .instr_i,
      .zadd_valid_i, .zadd_i, .dual_level_feature_i, .index_reg_one_i, .index_reg_two_i,
      .dev_status_i, .interrupt_pending_i, .int_level7_reset_done_i, .done_o,
      .instruction_pointer_o, .level_switch_o, .reentry_addr_o, .addr_recall_o, .flags_o,
      .program_mode_reg_o, .diag_slow_o, .supervisor_request_o, .level0_reset_o,
      .level7_enable_o, .level7_reset_o, .loop_wait_o
   );
   lacx_dev_model u_dev
   (
      .ref_clk_i, .set_i(st_set), .cond_i(st_val), .dev_status_o(dev_status_i)
   );
   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic step();
      @(posedge ref_clk_i);
      #5;
   endtask : step
   task automatic run(input logic [7:0] op, q, r, input logic [15:0] opd, ad);
      int n;
      step();
      instr_i = {op, q, r, opd, ad};
      start_i = 1'b1;
      step();
      start_i = 1'b0;
      n = 0;
      while (done_o !== 1'b1 && n < 8)
      begin
         step();
         n++;
      end
      chk("done", 16'h0001, {15'h0000, done_o});
   endtask : run
   task automatic nop();
      run(8'hC0, 8'h80, 8'h00, 16'h0000, 16'h0400);
   endtask : nop
   task automatic zadd(input logic z, n, c, input logic [7:0] e);
      step();
      zadd_i = {z, n, c};
      zadd_valid_i = 1'b1;
      step();
      zadd_valid_i = 1'b0;
      chk("flags", e, flags_o);
   endtask : zadd
   task automatic t_branch();
      logic [7:0] q[12] = '{8'h80, 8'h07, 8'h0F, 8'h88, 8'h88, 8'h87, 8'h8F, 8'h00, 8'h40,
         8'h04, 8'h02, 8'h10};
      logic [11:0] tk = 12'h17D;
      for (int i = 0; i < 12; i++)
      begin
         run(8'hC0, q[i], 8'h00, 16'h2468, 16'h0100);
         chk("ip", tk[11-i] ? 16'h2468 : 16'h0104, instruction_pointer_o);
         if (i == 3)
            chk("recall", 16'h0104, addr_recall_o);
      end
      chk("flags", 16'h0040, flags_o);
      run(8'hD0, 8'h00, 8'h00, 16'h0010, 16'h0200);
      chk("ip", 16'h1010, instruction_pointer_o);
      run(8'hE0, 8'h00, 8'h00, 16'h0010, 16'h0200);
      chk("ip", 16'h2010, instruction_pointer_o);
      run(8'hD0, 8'h80, 8'h00, 16'h0010, 16'h0200);
      chk("ip", 16'h0203, instruction_pointer_o);
   endtask : t_branch
   task automatic lv(input logic f, input logic [7:0] st, q, input logic sw, lp);
      logic [7:0] fl;
      step();
      fl = flags_o;
      dual_level_feature_i = f;
      st_val = st;
      st_set = 1'b1;
      step();
      st_set = 1'b0;
      repeat (5) step();
      run(8'hF1, q, 8'h00, 16'h0000, 16'h0300);
      chk("switch", sw, level_switch_o);
      if (sw)
         chk("reentry", q == 8'h00 ? 16'h0303 : 16'h0300, reentry_addr_o);
      else
         chk("ip", lp ? 16'h0300 : 16'h0303, instruction_pointer_o);
      chk("loop", lp, loop_wait_o);
      chk("flags", fl, flags_o);
   endtask : lv
   task automatic t_cmd();
      run(8'hF4, 8'h10, 8'h00, 16'h0000, 16'h0500);
      chk("svc", 16'h0001, supervisor_request_o);
      run(8'hF4, 8'h10, 8'h02, 16'h0000, 16'h0500);
      chk("lvl0", 16'h0001, level0_reset_o);
      chk("svc", 16'h0000, supervisor_request_o);
      for (logic [7:0] a = 8'h00; a < 8'h04; a++)
      begin
         run(8'hF4, 8'h20, a, 16'h0000, 16'h0500);
         chk("lvl7en", a[0], level7_enable_o);
         chk("lvl7rst", a[1], level7_reset_o);
      end
      run(8'hF4, 8'h30, 8'hFF, 16'h0000, 16'h0500);
      chk("mode", 16'h0000, program_mode_reg_o);
      nop();
      chk("mode", 16'h007F, program_mode_reg_o);
      run(8'hF4, 8'h40, 8'h00, 16'h0000, 16'h0500);
      chk("slow", 16'h0000, diag_slow_o);
      nop();
      chk("slow", 16'h0001, diag_slow_o);
      run(8'hF4, 8'h40, 8'h02, 16'h0000, 16'h0500);
      nop();
      chk("slow", 16'h0000, diag_slow_o);
      run(8'hF4, 8'h40, 8'h00, 16'h0000, 16'h0500);
      nop();
      initial_program_load_i = 1'b1;
      step();
      initial_program_load_i = 1'b0;
      chk("slow", 16'h0000, diag_slow_o);
      chk("flags", 16'h0040, flags_o);
   endtask : t_cmd
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         print_verdict();
      end
   end
   initial
   begin
      {fail_count, num_checks, cycles} = '0;
      {rst_n_i, initial_program_load_i, start_i, zadd_valid_i, dual_level_feature_i} = '0;
      {interrupt_pending_i, int_level7_reset_done_i, instr_i, zadd_i, st_val} = '0;
      clk_en_i = 1'b1;
      st_set = 1'b1;
      index_reg_one_i = 16'h1000;
      index_reg_two_i = 16'h2000;
      repeat (8) @(posedge ref_clk_i);
      #5;
      rst_n_i = 1'b1;
      st_set = 1'b0;
      chk("slow", 16'h0000, diag_slow_o);
      zadd(1'b1, 1'b0, 1'b0, 8'h80);
      zadd(1'b0, 1'b1, 1'b1, 8'h50);
      zadd(1'b0, 1'b0, 1'b0, 8'h30);
      zadd(1'b0, 1'b1, 1'b0, 8'h50);
      t_branch();
      lv(1'b1, 8'h02, 8'h21, 1'b1, 1'b0);
      lv(1'b1, 8'h00, 8'h21, 1'b0, 1'b0);
      lv(1'b1, 8'h08, 8'h53, 1'b1, 1'b0);
      lv(1'b0, 8'h02, 8'h21, 1'b0, 1'b1);
      lv(1'b0, 8'h00, 8'h21, 1'b0, 1'b0);
      lv(1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
      lv(1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
      lv(1'b1, 8'h00, 8'h05, 1'b1, 1'b0);
      lv(1'b0, 8'h00, 8'h05, 1'b0, 1'b1);
      t_cmd();
      run(8'hF4, 8'h40, 8'h00, 16'h0000, 16'h0500);
      nop();
      rst_n_i = 1'b0;
      step();
      rst_n_i = 1'b1;
      chk("slow", 16'h0000, diag_slow_o);
      print_verdict();
   end
endmodule : lacx_exec_tb_top
